/* rtl/acsfe_front_end.sv */
`timescale 1ns/1ps

// What this block does
// - Command register at 0x00 is 8 bits, write only, never read back.
// - Command byte sets direction and target register of the next transfer.
// - After reset or a finished transfer, wait for a new command byte.
// - 32 serial clocks with data in high and select low reset the interface.
// - That long-ones reset pulses the device reset and clears pairing, mode channel and command outputs.
// - Command bit 6: zero announces write, one announces read.
// - Command bits 5 to 0 are the target register address.
// - For per-channel registers, address bits 2 to 0 give the channel.
// - A mode register write applies its operation to the addressed channel.
// - The two pairing bits of a channel setup pick single or differential.
// - Single: input n against common; differential: pair 2(n mod 4), +1.
// - One mode register at eight write addresses; read it at 0x38 only.
// - Result and setup groups take eight addresses each, indexed by channel.
module acsfe_front_end
#(
	parameter int RESET_PULSE = acsfe_pkg::DEV_RESET_CYCLES
)
(
	// System clock and reset
	input  wire logic        clock,
	input  wire logic        rst_n,
	// Serial link from the host
	input  wire logic        sclk,
	input  wire logic        cs_n,
	input  wire logic        din,
	// Result width setting from the mode logic
	input  wire logic        wide_results,
	// Decoded command
	output logic             cmd_valid,
	output logic             cmd_read,
	output logic [5:0]       reg_addr,
	output logic [2:0]       channel,
	output logic             read_request,
	output logic             cmd_refused,
	// Completed register writes and transfer ends
	output logic             write_valid,
	output logic [5:0]       write_addr,
	output logic [23:0]      write_data,
	output logic             xfer_done,
	// Mode operation target
	output logic             mode_write,
	output logic [2:0]       mode_channel,
	// Input routing of the mode channel
	output logic [2:0]       route_pos,
	output logic [2:0]       route_neg,
	output logic             route_common,
	// Device-wide reset request
	output logic             device_reset
);

	localparam int RST_W = $clog2(RESET_PULSE + 1);

	// ------------------------------------------------------------
	// Link domain state, clocked by the serial clock
	// ------------------------------------------------------------
	typedef struct packed {
		acsfe_pkg::acsfe_phase_t                    phase;
		logic [acsfe_pkg::WORD_BITS-1:0]            shift;
		logic [acsfe_pkg::CNT_BITS-1:0]             bits;
		logic [acsfe_pkg::CNT_BITS-1:0]             need;
		logic [acsfe_pkg::ONES_BITS-1:0]            ones;
		logic                                       cmd_read;
		logic [acsfe_pkg::ADDR_BITS-1:0]            cmd_addr;
		logic [acsfe_pkg::WORD_BITS-1:0]            wr_word;
		logic [acsfe_pkg::TG_COUNT-1:0]             tgl;
	} acsfe_link_t;

	// ------------------------------------------------------------
	// System domain state
	// ------------------------------------------------------------
	typedef struct packed {
		logic [acsfe_pkg::TG_COUNT-1:0]             seen;
		logic                                       wide;
		logic                                       cmd_valid;
		logic                                       cmd_read;
		logic [acsfe_pkg::ADDR_BITS-1:0]            reg_addr;
		logic [acsfe_pkg::CHAN_BITS-1:0]            channel;
		logic                                       read_request;
		logic                                       cmd_refused;
		logic                                       write_valid;
		logic [acsfe_pkg::ADDR_BITS-1:0]            write_addr;
		logic [acsfe_pkg::WORD_BITS-1:0]            write_data;
		logic                                       xfer_done;
		logic                                       mode_write;
		logic [acsfe_pkg::CHAN_BITS-1:0]            mode_channel;
		logic [acsfe_pkg::CHANNELS-1:0][1:0]        pairing;
		logic [acsfe_pkg::CHAN_BITS-1:0]            route_pos;
		logic [acsfe_pkg::CHAN_BITS-1:0]            route_neg;
		logic                                       route_common;
		logic [RST_W-1:0]                           rst_cnt;
		logic                                       device_reset;
	} acsfe_sys_t;

	acsfe_link_t                    lk_reg;
	acsfe_link_t                    lk_next;
	acsfe_sys_t                     sy_reg;
	acsfe_sys_t                     sy_next;
	logic                           wide_link;
	logic [acsfe_pkg::TG_COUNT-1:0] tgl_sys;

	// ------------------------------------------------------------
	// Domain crossings
	// ------------------------------------------------------------

	// Result width reaches the link a few serial clocks late; set it before the frame
	acsfe_sync
	#(
		.WIDTH    (1)
	)
	u_wide_sync
	(
		.clock    (sclk),
		.rst_n    (rst_n),
		.async_in (sy_reg.wide),
		.sync_out (wide_link)
	);

	// Event toggles; the words they qualify stay still until the next event
	acsfe_sync
	#(
		.WIDTH    (acsfe_pkg::TG_COUNT)
	)
	u_event_sync
	(
		.clock    (clock),
		.rst_n    (rst_n),
		.async_in (lk_reg.tgl),
		.sync_out (tgl_sys)
	);

	// ------------------------------------------------------------
	// Link logic
	// ------------------------------------------------------------

	// Shift, decode and data phase count; only edges with select low count
	always_comb
	begin
		logic [acsfe_pkg::CMD_BITS-1:0]  cmd_byte;
		logic [acsfe_pkg::WORD_BITS-1:0] word_in;
		logic [acsfe_pkg::ADDR_BITS-1:0] addr_in;
		cmd_byte = {lk_reg.shift[acsfe_pkg::CMD_BITS-2:0], din};
		word_in  = {lk_reg.shift[acsfe_pkg::WORD_BITS-2:0], din};
		addr_in  = cmd_byte[acsfe_pkg::ADDR_BITS-1:0];
		lk_next  = lk_reg;
		if (cs_n)
		begin
			lk_next.ones = '0;
		end
		else if (din && lk_reg.ones == acsfe_pkg::ONES_RESET - 6'h01)
		begin
			// Counted in every phase, reads included, so long reads need din low
			lk_next.ones  = acsfe_pkg::ONES_RESET;
			lk_next.phase = acsfe_pkg::LK_COMMAND;
			lk_next.bits  = '0;
			lk_next.shift = '0;
			lk_next.tgl[acsfe_pkg::TG_RST] = ~lk_reg.tgl[acsfe_pkg::TG_RST];
		end
		else if (din && lk_reg.ones == acsfe_pkg::ONES_RESET)
		begin
			// Ones past the reset point are no command bits; wait for a zero
			lk_next.bits = '0;
		end
		else
		begin
			// Saturate so one long run of ones gives a single reset
			if (!din)
				lk_next.ones = '0;
			else if (lk_reg.ones != acsfe_pkg::ONES_RESET)
				lk_next.ones = lk_reg.ones + 6'h01;
			lk_next.shift = word_in;
			lk_next.bits  = lk_reg.bits + 5'h01;
			unique case (lk_reg.phase)
				acsfe_pkg::LK_COMMAND:
				begin
					if (lk_reg.bits == 5'(acsfe_pkg::CMD_BITS - 1))
					begin
						lk_next.bits     = '0;
						lk_next.cmd_read = cmd_byte[acsfe_pkg::CMD_DIR_BIT];
						lk_next.cmd_addr = addr_in;
						lk_next.need     = acsfe_pkg::reg_bits(addr_in, wide_link);
						lk_next.tgl[acsfe_pkg::TG_CMD] = ~lk_reg.tgl[acsfe_pkg::TG_CMD];
						// Address 0x00 has no data phase: next byte is a command
						if (addr_in == acsfe_pkg::CMD_REG_ADDR)
							lk_next.phase = acsfe_pkg::LK_COMMAND;
						else if (cmd_byte[acsfe_pkg::CMD_DIR_BIT])
							lk_next.phase = acsfe_pkg::LK_READ;
						else
							lk_next.phase = acsfe_pkg::LK_WRITE;
					end
				end
				acsfe_pkg::LK_WRITE, acsfe_pkg::LK_READ:
				begin
					if (lk_reg.bits == lk_reg.need - 5'h01)
					begin
						lk_next.bits  = '0;
						lk_next.phase = acsfe_pkg::LK_COMMAND;
						lk_next.tgl[acsfe_pkg::TG_DONE] = ~lk_reg.tgl[acsfe_pkg::TG_DONE];
						if (lk_reg.phase == acsfe_pkg::LK_WRITE)
						begin
							// Keep only the data bits; older command bits are masked off
							lk_next.wr_word = word_in
								& ~({acsfe_pkg::WORD_BITS{1'b1}} << lk_reg.need);
							lk_next.tgl[acsfe_pkg::TG_WR] = ~lk_reg.tgl[acsfe_pkg::TG_WR];
						end
					end
				end
				default:
				begin
					lk_next.phase = acsfe_pkg::LK_COMMAND;
					lk_next.bits  = '0;
				end
			endcase
		end
	end

	// Link registers; the serial clock may stop between frames
	always_ff @(posedge sclk or negedge rst_n)
	begin
		if (!rst_n)
			lk_reg <= '0;
		else
			lk_reg <= lk_next;
	end

	// ------------------------------------------------------------
	// System side decode
	// ------------------------------------------------------------

	// Handles events from the link and keeps channel routing
	always_comb
	begin
		logic [acsfe_pkg::TG_COUNT-1:0]  evt;
		logic [acsfe_pkg::CHAN_BITS-1:0] grp;
		logic [acsfe_pkg::CHAN_BITS-1:0] chn;
		logic [1:0]                      pair;
		evt  = tgl_sys ^ sy_reg.seen;
		grp  = lk_reg.cmd_addr[acsfe_pkg::ADDR_BITS-1:acsfe_pkg::CHAN_BITS];
		chn  = lk_reg.cmd_addr[acsfe_pkg::CHAN_BITS-1:0];
		pair = sy_reg.pairing[sy_reg.mode_channel];
		sy_next              = sy_reg;
		sy_next.seen         = tgl_sys;
		sy_next.wide         = wide_results;
		sy_next.cmd_valid    = 1'b0;
		sy_next.read_request = 1'b0;
		sy_next.cmd_refused  = 1'b0;
		sy_next.write_valid  = 1'b0;
		sy_next.xfer_done    = 1'b0;
		sy_next.mode_write   = 1'b0;

		// New command: show it and ask for read data where allowed
		if (evt[acsfe_pkg::TG_CMD])
		begin
			sy_next.cmd_valid = 1'b1;
			sy_next.cmd_read  = lk_reg.cmd_read;
			sy_next.reg_addr  = lk_reg.cmd_addr;
			sy_next.channel   = chn;
			if (lk_reg.cmd_read && lk_reg.cmd_addr == acsfe_pkg::CMD_REG_ADDR)
				sy_next.cmd_refused = 1'b1;
			else if (lk_reg.cmd_read && grp == acsfe_pkg::GRP_MODE
				&& lk_reg.cmd_addr != acsfe_pkg::MODE_READ_ADDR)
				sy_next.cmd_refused = 1'b1;
			else if (lk_reg.cmd_read)
				sy_next.read_request = 1'b1;
		end

		// Finished transfer
		if (evt[acsfe_pkg::TG_DONE])
			sy_next.xfer_done = 1'b1;

		// Finished write: pass the word on, catch setup pairing and mode target
		if (evt[acsfe_pkg::TG_WR])
		begin
			sy_next.write_valid = 1'b1;
			sy_next.write_addr  = lk_reg.cmd_addr;
			sy_next.write_data  = lk_reg.wr_word;
			if (grp == acsfe_pkg::GRP_SETUP)
				sy_next.pairing[chn] = {lk_reg.wr_word[acsfe_pkg::PAIR_HI_BIT],
					lk_reg.wr_word[acsfe_pkg::PAIR_LO_BIT]};
			if (grp == acsfe_pkg::GRP_MODE)
			begin
				sy_next.mode_write   = 1'b1;
				sy_next.mode_channel = chn;
			end
		end

		// Routing of the mode channel, single-ended or paired
		if (pair == acsfe_pkg::PAIR_SINGLE)
		begin
			sy_next.route_pos    = sy_reg.mode_channel;
			sy_next.route_neg    = '0;
			sy_next.route_common = 1'b1;
		end
		else
		begin
			sy_next.route_pos    = {sy_reg.mode_channel[1:0], 1'b0};
			sy_next.route_neg    = {sy_reg.mode_channel[1:0], 1'b1};
			sy_next.route_common = 1'b0;
		end

		// Long-ones reset: clear pairing, mode channel and command and write outputs, and pulse the device reset
		if (evt[acsfe_pkg::TG_RST])
		begin
			sy_next.pairing      = '0;
			sy_next.mode_channel = '0;
			sy_next.cmd_read     = 1'b0;
			sy_next.reg_addr     = '0;
			sy_next.channel      = '0;
			sy_next.write_addr   = '0;
			sy_next.write_data   = '0;
			sy_next.rst_cnt      = RST_W'(RESET_PULSE);
			sy_next.device_reset = 1'b1;
		end
		else if (sy_reg.rst_cnt != '0)
		begin
			sy_next.rst_cnt      = sy_reg.rst_cnt - RST_W'(1);
			sy_next.device_reset = sy_reg.rst_cnt != RST_W'(1);
		end
	end

	// System registers
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			sy_reg <= '0;
		else
			sy_reg <= sy_next;
	end

	// ------------------------------------------------------------
	// Outputs, all straight from system flip-flops
	// ------------------------------------------------------------
	assign cmd_valid    = sy_reg.cmd_valid;
	assign cmd_read     = sy_reg.cmd_read;
	assign reg_addr     = sy_reg.reg_addr;
	assign channel      = sy_reg.channel;
	assign read_request = sy_reg.read_request;
	assign cmd_refused  = sy_reg.cmd_refused;
	assign write_valid  = sy_reg.write_valid;
	assign write_addr   = sy_reg.write_addr;
	assign write_data   = sy_reg.write_data;
	assign xfer_done    = sy_reg.xfer_done;
	assign mode_write   = sy_reg.mode_write;
	assign mode_channel = sy_reg.mode_channel;
	assign route_pos    = sy_reg.route_pos;
	assign route_neg    = sy_reg.route_neg;
	assign route_common = sy_reg.route_common;
	assign device_reset = sy_reg.device_reset;

endmodule // acsfe_front_end

/* rtl/acsfe_pkg.sv */
package acsfe_pkg;

	// ------------------------------------------------------------
	// Widths of the command byte and its fields
	// ------------------------------------------------------------
	localparam int CMD_BITS  = 8;
	localparam int ADDR_BITS = 6;
	localparam int CHAN_BITS = 3;
	localparam int WORD_BITS = 24;
	localparam int CNT_BITS  = 5;
	localparam int ONES_BITS = 6;
	localparam int CHANNELS  = 8;

	// Command byte layout
	localparam int CMD_ZERO_BIT = 7;
	localparam int CMD_DIR_BIT  = 6;

	// ------------------------------------------------------------
	// Register map, by address group (upper three address bits)
	// ------------------------------------------------------------
	localparam logic [ADDR_BITS-1:0] CMD_REG_ADDR   = 6'h00;
	localparam logic [ADDR_BITS-1:0] MODE_READ_ADDR = 6'h38;
	localparam logic [CHAN_BITS-1:0] GRP_SYSTEM  = 3'h0;
	localparam logic [CHAN_BITS-1:0] GRP_DATA    = 3'h1;
	localparam logic [CHAN_BITS-1:0] GRP_CHAN_ZS = 3'h2;
	localparam logic [CHAN_BITS-1:0] GRP_CHAN_FS = 3'h3;
	localparam logic [CHAN_BITS-1:0] GRP_STATUS  = 3'h4;
	localparam logic [CHAN_BITS-1:0] GRP_SETUP   = 3'h5;
	localparam logic [CHAN_BITS-1:0] GRP_CONV    = 3'h6;
	localparam logic [CHAN_BITS-1:0] GRP_MODE    = 3'h7;
	localparam logic [CHAN_BITS-1:0] SYS_TEST     = 3'h3;
	localparam logic [CHAN_BITS-1:0] SYS_CHECKSUM = 3'h5;
	localparam logic [CHAN_BITS-1:0] SYS_ADC_ZS   = 3'h6;

	// Data phase lengths in serial clocks
	localparam logic [CNT_BITS-1:0] LEN_BYTE = 5'h08;
	localparam logic [CNT_BITS-1:0] LEN_HALF = 5'h10;
	localparam logic [CNT_BITS-1:0] LEN_FULL = 5'h18;

	// Long-ones interface reset length
	localparam logic [ONES_BITS-1:0] ONES_RESET = 6'h20;

	// Setup register input pairing field
	localparam int PAIR_HI_BIT = 6;
	localparam int PAIR_LO_BIT = 5;
	localparam logic [1:0] PAIR_SINGLE = 2'h0;

	// Length of the device-wide reset pulse, in system clocks
	localparam int DEV_RESET_CYCLES = 8;

	// Toggle lanes from the link domain
	localparam int TG_CMD   = 0;
	localparam int TG_WR    = 1;
	localparam int TG_DONE  = 2;
	localparam int TG_RST   = 3;
	localparam int TG_COUNT = 4;

	typedef enum logic [1:0] {LK_COMMAND, LK_WRITE, LK_READ} acsfe_phase_t;

	// Data phase length of the register at an address
	function automatic logic [CNT_BITS-1:0] reg_bits(input logic [ADDR_BITS-1:0] addr,
		input logic wide);
		logic [CHAN_BITS-1:0] grp;
		logic [CHAN_BITS-1:0] sub;
		grp = addr[ADDR_BITS-1:CHAN_BITS];
		sub = addr[CHAN_BITS-1:0];
		reg_bits = LEN_BYTE;
		if (grp == GRP_DATA)
			reg_bits = wide ? LEN_FULL : LEN_HALF;
		else if (grp == GRP_CHAN_ZS || grp == GRP_CHAN_FS)
			reg_bits = LEN_FULL;
		else if (grp == GRP_SYSTEM && (sub == SYS_TEST || sub >= SYS_ADC_ZS))
			reg_bits = LEN_FULL;
		else if (grp == GRP_SYSTEM && sub == SYS_CHECKSUM)
			reg_bits = LEN_HALF;
	endfunction

endpackage

/* rtl/acsfe_sync.sv */
`timescale 1ns/1ps

// Three-stage synchroniser; a bit changes once stages two and three agree
module acsfe_sync
#(
	parameter int WIDTH = 1
)
(
	// Destination clock and reset
	input  wire logic             clock,
	input  wire logic             rst_n,
	// Crossing bits
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);

	typedef struct packed {
		logic [WIDTH-1:0] s1;
		logic [WIDTH-1:0] s2;
		logic [WIDTH-1:0] s3;
		logic [WIDTH-1:0] held;
	} acsfe_sync_t;

	acsfe_sync_t st_reg;
	acsfe_sync_t st_next;

	// First stage feeds only the second; filter works on stages two and three
	always_comb
	begin
		st_next      = st_reg;
		st_next.s1   = async_in;
		st_next.s2   = st_reg.s1;
		st_next.s3   = st_reg.s2;
		st_next.held = (st_reg.held & (st_reg.s2 ^ st_reg.s3))
			| (st_reg.s3 & ~(st_reg.s2 ^ st_reg.s3));
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			st_reg <= '0;
		else
			st_reg <= st_next;
	end

	assign sync_out = st_reg.held;

endmodule // acsfe_sync

/* verification/acsfe_front_end_asserts.sv */
`timescale 1ns/1ps

// ----------------------------------------
// Port checks of the command front end
// ----------------------------------------
module acsfe_front_end_asserts
#(
	parameter int RESET_PULSE = 8
)
(
	// Clocks and reset
	input wire logic        clock,
	input wire logic        rst_n,
	input wire logic        sclk,
	// Serial link and mode input
	input wire logic        cs_n,
	input wire logic        din,
	input wire logic        wide_results,
	// Decoded command
	input wire logic        cmd_valid,
	input wire logic        cmd_read,
	input wire logic [5:0]  reg_addr,
	input wire logic [2:0]  channel,
	input wire logic        read_request,
	input wire logic        cmd_refused,
	// Writes, transfer ends, routing and device reset
	input wire logic        write_valid,
	input wire logic [5:0]  write_addr,
	input wire logic [23:0] write_data,
	input wire logic        xfer_done,
	input wire logic        mode_write,
	input wire logic [2:0]  mode_channel,
	input wire logic [2:0]  route_pos,
	input wire logic [2:0]  route_neg,
	input wire logic        route_common,
	input wire logic        device_reset
);
	logic [7:0] hi_cnt_reg;

	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);

	// Length of the current reset pulse, read when it falls
	always_ff @(posedge clock or negedge rst_n)
		if (!rst_n)
			hi_cnt_reg <= 8'h00;
		else
			hi_cnt_reg <= device_reset ? hi_cnt_reg + 8'h01 : 8'h00;

	a_read_request: assert property (
		read_request |-> cmd_valid && cmd_read && !cmd_refused)
		else $error("read request without a read command");
	a_refuse_cause: assert property (
		cmd_refused |-> cmd_valid && cmd_read
		&& (reg_addr == 6'h00 || (reg_addr[5:3] == 3'h7 && reg_addr != 6'h38)))
		else $error("refusal of a legal command");
	a_legal_read: assert property (
		cmd_valid && cmd_read && reg_addr != 6'h00
		&& (reg_addr[5:3] != 3'h7 || reg_addr == 6'h38) |-> read_request)
		else $error("legal read not requested");
	a_chan_field: assert property (cmd_valid |-> channel == reg_addr[2:0])
		else $error("channel differs from low address bits");
	a_write_done: assert property (write_valid |-> xfer_done)
		else $error("write finished without transfer end");
	a_mode_decode: assert property (
		write_valid |-> mode_write == (write_addr[5:3] == 3'h7))
		else $error("mode write decode wrong");
	a_mode_chan: assert property (
		mode_write |=> mode_channel == $past(write_addr[2:0]))
		else $error("mode channel not from write address");
	a_route_single: assert property (route_common |-> route_neg == 3'h0)
		else $error("single input routing wrong");
	a_route_pair: assert property (
		!route_common && !device_reset && $past(rst_n) && !$past(device_reset)
		|-> !route_pos[0] && route_neg == {route_pos[2:1], 1'b1})
		else $error("differential pair routing wrong");
	a_reset_len: assert property ($fell(device_reset) |-> hi_cnt_reg == RESET_PULSE)
		else $error("device reset pulse length wrong");

	c_refused: cover property (cmd_refused);
	c_mode: cover property (mode_write);
	c_reset: cover property ($rose(device_reset));
	c_read: cover property (read_request);
endmodule // acsfe_front_end_asserts

bind acsfe_front_end acsfe_front_end_asserts #(.RESET_PULSE(RESET_PULSE)) acsfe_front_end_asserts_i
(
	.clock(clock), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n), .din(din),
	.wide_results(wide_results), .cmd_valid(cmd_valid), .cmd_read(cmd_read),
	.reg_addr(reg_addr), .channel(channel), .read_request(read_request),
	.cmd_refused(cmd_refused), .write_valid(write_valid), .write_addr(write_addr),
	.write_data(write_data), .xfer_done(xfer_done), .mode_write(mode_write),
	.mode_channel(mode_channel), .route_pos(route_pos), .route_neg(route_neg),
	.route_common(route_common), .device_reset(device_reset)
);

/* verification/acsfe_host_model.sv */
`timescale 1ns/1ps

// ----------------------------------------
// Host serial master model
// ----------------------------------------
module acsfe_host_model
(
	// Serial link to the device
	output logic sclk,
	output logic cs_n,
	output logic din
);
	// Clock stands high between frames
	initial
	begin
		sclk = 1'b1;
		cs_n = 1'b1;
		din = 1'b0;
	end

	// Bits leave MSB first, each taken on the rising sclk edge
	task automatic shift(input logic [31:0] v, input int n, input logic halt);
		#13; // Off the system clock edges; keeps back-to-back frames apart
		cs_n = 1'b0;
		for (int i = n - 1; i >= 0; i--)
		begin
			if (halt && i == n / 2)
			begin
				cs_n = 1'b1; // A pause only; the frame goes on afterwards
				#400;
				cs_n = 1'b0;
			end
			sclk = 1'b0;
			din = v[i];
			#80;
			sclk = 1'b1;
			#80;
		end
		cs_n = 1'b1;
		din = ~din; // Released line must not show a stale level
	endtask

	// Every transaction opens with a command byte, top bit zero
	task automatic command(input logic rd, input logic [5:0] a);
		shift({24'h000000, 1'b0, rd, a}, 8, 1'b0);
	endtask

	// Reads keep the data line low so no long-ones reset fires
	task automatic read_phase(input int n);
		shift(32'h00000000, n, 1'b0);
	endtask
endmodule // acsfe_host_model

/* verification/tb_top.sv */
`timescale 1ns/1ps

// ----------------------------------------
// Self-checking bench of the front end
// ----------------------------------------
module tb_top;
	logic        clock, rst_n, sclk, cs_n, din, wide_results;
	logic        cmd_valid, cmd_read, read_request, cmd_refused;
	logic        write_valid, xfer_done, mode_write, route_common, device_reset;
	logic [5:0]  reg_addr, write_addr;
	logic [2:0]  channel, mode_channel, route_pos, route_neg;
	logic [23:0] write_data;
	logic [31:0] seed;
	logic [11:0] cq[$];
	logic [29:0] wq[$];
	logic [5:0]  wa[6] = '{6'h01, 6'h05, 6'h06, 6'h13, 6'h2A, 6'h31};
	int          err_count, total_checks, done_seen, done_exp, k;

	// System clock, 40 ns
	initial clock = 1'b0;
	always #20 clock = ~clock;

	acsfe_front_end #(.RESET_PULSE(8)) acsfe_front_end_i
	(
		.clock(clock), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n), .din(din),
		.wide_results(wide_results), .cmd_valid(cmd_valid), .cmd_read(cmd_read),
		.reg_addr(reg_addr), .channel(channel), .read_request(read_request),
		.cmd_refused(cmd_refused), .write_valid(write_valid), .write_addr(write_addr),
		.write_data(write_data), .xfer_done(xfer_done), .mode_write(mode_write),
		.mode_channel(mode_channel), .route_pos(route_pos), .route_neg(route_neg),
		.route_common(route_common), .device_reset(device_reset)
	);
	acsfe_host_model acsfe_host_model_i (.sclk(sclk), .cs_n(cs_n), .din(din));

	task automatic results;
		if (err_count == 0 && total_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp)
		begin
			err_count++;
			$display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
		end
	endtask

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	// Data phase length in bits, from the register map
	function automatic int dlen(input logic [5:0] a);
		if (a[5:3] == 3'h1)
			return wide_results ? 24 : 16;
		if (a[5:3] == 3'h2 || a[5:3] == 3'h3 || a == 6'h03 || a == 6'h06 || a == 6'h07)
			return 24;
		return (a == 6'h05) ? 16 : 8;
	endfunction

	// Wait until every queued command and write has been seen, then let pulses land
	task automatic settle;
		for (k = 0; k < 300 && (cq.size() + wq.size()) != 0; k++)
			@(negedge clock);
		if (k == 300)
		begin
			err_count++;
			results();
		end
		repeat (8) @(negedge clock);
	endtask

	// One transaction; expectations are queued before the host sends
	task automatic op(input logic rd, input logic [5:0] a, input logic [23:0] d, input logic halt);
		int n;
		logic refused;
		n = dlen(a);
		refused = rd && (a == 6'h00 || (a[5:3] == 3'h7 && a != 6'h38));
		d = (n == 24) ? d : ((n == 16) ? {8'h00, d[15:0]} : {16'h0000, d[7:0]});
		cq.push_back({rd, refused, rd && !refused, a, a[2:0]});
		acsfe_host_model_i.command(rd, a);
		if (a != 6'h00)
		begin
			done_exp++;
			if (rd)
				acsfe_host_model_i.read_phase(n);
			else
			begin
				wq.push_back({a, d});
				acsfe_host_model_i.shift({8'h00, d}, n, halt);
			end
		end
		settle();
	endtask

	// Setup pairing of channel c, then run a mode write on it
	task automatic route(input logic [2:0] c, input logic [1:0] p);
		op(1'b0, {3'h5, c}, {17'h00000, p, 5'h00}, 1'b0);
		op(1'b0, {3'h7, c}, 24'h000002, 1'b0);
		chk("mode_channel", c, mode_channel);
		chk("route",
			(p == 2'h0) ? {1'b1, c, 3'h0} : {1'b0, c[1:0], 1'b0, c[1:0], 1'b1},
			{route_common, route_pos, route_neg});
	endtask

	// Each command and write is compared with the oldest expectation; transfer ends are counted
	always @(negedge clock)
	begin
		if (cmd_valid === 1'b1)
			chk("command", (cq.size() != 0) ? cq.pop_front() : 12'hFFF,
				{cmd_read, cmd_refused, read_request, reg_addr, channel});
		if (write_valid === 1'b1)
		begin
			chk("write", (wq.size() != 0) ? wq.pop_front() : 30'h3FFFFFFF,
				{write_addr, write_data});
			chk("mode_write", write_addr[5:3] == 3'h7, mode_write);
		end
		if (xfer_done === 1'b1)
			done_seen++;
	end

	// Main sequence
	initial
	begin
		rst_n = 1'b0;
		wide_results = 1'b0;
		seed = 32'h6656;
		repeat (6) @(negedge clock);
		rst_n = 1'b1;
		repeat (4) @(negedge clock);
		chk("route_common", 1, route_common);
		op(1'b1, 6'h00, 24'h000000, 1'b0);
		op(1'b0, 6'h00, 24'h000000, 1'b0);
		op(1'b1, 6'h39, 24'h000000, 1'b0);
		op(1'b1, 6'h38, 24'h000000, 1'b0);
		op(1'b1, 6'h0B, 24'h000000, 1'b0);
		wide_results = 1'b1;
		op(1'b1, 6'h0F, 24'h000000, 1'b0);
		for (int i = 0; i < 6; i++)
		begin
			seed = lfsr(seed);
			op(1'b0, wa[i], seed[23:0], i == 2);
		end
		for (int c = 0; c < 8; c++)
		begin
			seed = lfsr(seed);
			route(c[2:0], c[0] ? 2'h0 : (seed[1:0] | 2'h1));
		end
		// Long ones: two refused reads of 0x3F go by before the reset
		cq.push_back(12'hDFF);
		cq.push_back(12'hDFF);
		done_exp++;
		acsfe_host_model_i.shift(32'hFFFFFFFF, 32, 1'b0);
		for (k = 0; k < 20 && device_reset !== 1'b1; k++)
			@(negedge clock);
		for (k = 0; k < 40 && device_reset === 1'b1; k++)
			@(negedge clock);
		chk("reset_pulse", 8, k);
		repeat (4) @(negedge clock);
		chk("route_cleared", 7'h40, {route_common, route_pos, route_neg});
		op(1'b1, 6'h38, 24'h000000, 1'b0);
		chk("done_count", done_exp, done_seen);
		results();
	end
endmodule // tb_top
